// ### common/nlao_params.svh
// command codes, address sequencing, status constants and timing figures of the lun sequencer
`ifndef NLAO_PARAMS_SVH
`define NLAO_PARAMS_SVH

`define NLAO_CMD_READ        8'h00
`define NLAO_CMD_READ_GO     8'h30
`define NLAO_CMD_CB_READ     8'h35
`define NLAO_CMD_CRD_SEQ     8'h31
`define NLAO_CMD_CRD_END     8'h3F
`define NLAO_CMD_PROG        8'h80
`define NLAO_CMD_CB_PROG     8'h85
`define NLAO_CMD_PROG_GO     8'h10
`define NLAO_CMD_CPROG_GO    8'h15
`define NLAO_CMD_STATUS      8'h70
`define NLAO_CMD_STATUS_ENH  8'h78

`define NLAO_ADDR_COL0       3'h0
`define NLAO_ADDR_COL1       3'h1
`define NLAO_ADDR_ROW0       3'h2
`define NLAO_ADDR_ROW1       3'h3
`define NLAO_ADDR_ROW2       3'h4
`define NLAO_ADDR_DONE       3'h5

`define NLAO_LUN_SHIFT       20
`define NLAO_VSP_VALUE       1'b0
`define NLAO_SYNC_INIT       15'h1e00

`define NLAO_CLK_MHZ         200
`define NLAO_TR_NS           25000
`define NLAO_ARRAY_PROGRAM_TIME_NS        200000

`endif

// ### common/nlao_pkg.sv
// types shared by the lun sequencer modules
package nlao_pkg;

   typedef struct packed {
      logic cle;
      logic ale;
      logic ce_b;
      logic we_b;
      logic re_b;
      logic wp_b;
   } nlao_pins_t;

   typedef struct packed {
      logic       write_unprot;
      logic       lun_ready;
      logic       array_idle_bit;
      logic       vendor_status_bit;
      logic [1:0] rsvd;
      logic       prior_op_fail_bit;
      logic       last_op_fail;
   } nlao_status_t;

   typedef enum logic [1:0] {S_IDLE, S_WAITBG, S_COPY, S_TIMER} nlao_state_t;
   typedef enum logic [2:0] {OP_READ, OP_CRD_SEQ, OP_CRD_END, OP_PROG, OP_CPROG} nlao_op_t;
   typedef enum logic [1:0] {CP_A2H, CP_D2H, CP_A2D, CP_H2A} nlao_copy_t;

endpackage : nlao_pkg

// ### logic/nlao_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module nlao_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               meta_r[i] <= INIT[i];
               q[i]      <= INIT[i];
            end else begin
               meta_r[i] <= d[i];
               q[i]      <= meta_r[i];
            end
         end
      end
   endgenerate
endmodule : nlao_sync

// ### logic/nlao_store.sv
// flip-flop byte store with one write port and one indexed read port
`timescale 1ns/100ps
module nlao_store #(
   parameter int W     = 8,
   parameter int DEPTH = 16,
   localparam int AW   = $clog2(DEPTH)
) (
   input  wire logic          mclk,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem_r [DEPTH];

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("nlao_store depth must be a power of two of at least two");
      end
      for (genvar i = 0; i < DEPTH; i++) begin : g_ent
         // contents carry no reset: software must write before it reads
         always_ff @(posedge mclk) begin
            if (we && waddr == AW'(i)) begin
               mem_r[i] <= wdata;
            end
         end
      end
   endgenerate

   assign rdata = mem_r[raddr];
endmodule : nlao_store

// ### logic/nlao_top.sv
// nand lun command sequencer: status byte, page read, read cache, program, cache program, copyback
`timescale 1ns/100ps
`include "nlao_params.svh"

// Behaviour
// - status byte wp, ready, idle, vendor, 00, fails
// - last fail flags failed program, idle-valid
// - prior fail reports the program before last
// - array idle low while processing or array busy
// - ready bit means accept, drives busy pin
// - write-unprotected bit always valid
// - read loads page, outputs from column
// - column two bytes, row three, low first
// - command 00h resumes output at column
// - cache fetches next page, output column zero
// - 31h/3Fh busy until page copied
// - 3Fh starts no further background read
// - program loads from column, writes row page
// - program fail valid between ready edges
// - final 10h drains array before ready
// - cache program fail timing by idle, ready
// - copyback shares one page register
// - fail bits keep only the finishing interleave address
// - unselected lun keeps its drivers off
module nlao_top import nlao_pkg::*; #(
   parameter int         PAGE_BYTES = 16,
   parameter int         NPAGES     = 8,
   parameter int         NIL        = 2,
   parameter logic [3:0] LUN_ID     = 4'h0,
   parameter int         TR_CYC     = (`NLAO_TR_NS * `NLAO_CLK_MHZ + 999) / 1000,
   parameter int         ARRAY_PROGRAM_TIME_CYC  = (`NLAO_ARRAY_PROGRAM_TIME_NS * `NLAO_CLK_MHZ + 999) / 1000
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire nlao_pins_t pins,
   input  wire logic [7:0] io_in,
   input  wire logic       array_fault,
   output logic      [7:0] io_out,
   output logic            io_oe,
   output logic            rdy_bsy_b
);
   localparam int CAW  = $clog2(PAGE_BYTES);
   localparam int PAW  = $clog2(NPAGES);
   localparam int ILW  = $clog2(NIL);
   localparam int TMAX = (ARRAY_PROGRAM_TIME_CYC > TR_CYC) ? ARRAY_PROGRAM_TIME_CYC : TR_CYC;
   localparam int CW   = $clog2(TMAX + 1);
   localparam logic [CAW-1:0] COL_LAST = CAW'(PAGE_BYTES - 1);

   generate
      if (PAGE_BYTES < 2 || (1 << CAW) != PAGE_BYTES || NPAGES < 2 || (1 << PAW) != NPAGES ||
          NIL < 2 || (1 << ILW) != NIL || TR_CYC < 1 || ARRAY_PROGRAM_TIME_CYC < 1) begin : g_bad_param
         $error("nlao_top geometry must be powers of two and busy times at least one cycle");
      end
   endgenerate

   // ****************************************
   // pin synchronisers and strobes
   // ****************************************
   logic [14:0]  sync_q;
   nlao_pins_t   pins_s;
   logic [7:0]   io_s;
   logic         fault_s;
   logic         we_d_r;
   logic         re_d_r;

   nlao_sync #(.W(15), .INIT(`NLAO_SYNC_INIT)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     ({pins, io_in, array_fault}),
      .q     (sync_q)
   );
   assign pins_s  = nlao_pins_t'(sync_q[14:9]);
   assign io_s    = sync_q[8:1];
   assign fault_s = sync_q[0];

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         we_d_r <= 1'b1;
         re_d_r <= 1'b1;
      end else begin
         we_d_r <= pins_s.we_b;
         re_d_r <= pins_s.re_b;
      end
   end

   logic act, we_rise, re_fall, cmd_stb, addr_stb, data_stb;
   assign act      = !pins_s.ce_b;
   assign we_rise  = act && pins_s.we_b && !we_d_r;
   assign re_fall  = act && !pins_s.re_b && re_d_r;
   assign cmd_stb  = we_rise && pins_s.cle && !pins_s.ale;
   assign addr_stb = we_rise && pins_s.ale && !pins_s.cle;
   assign data_stb = we_rise && !pins_s.ale && !pins_s.cle;

   // ****************************************
   // state shared by host side and sequencer
   // ****************************************
   nlao_state_t    state_r;
   nlao_op_t       op_r;
   nlao_copy_t     kind_r;
   logic           ready_r;
   logic [CAW-1:0] cnt_r;
   logic [CW-1:0]  fg_cnt_r;
   logic [CW-1:0]  bg_cnt_r;
   logic           bg_prog_r;
   logic           launch_fail_r;
   logic [ILW-1:0] il_r;
   logic [PAW-1:0] arow_r;
   logic [NIL-1:0] last_fail_r;
   logic [NIL-1:0] prior_fail_r;
   logic [7:0]     cmd_r;
   logic [2:0]     addr_cnt_r;
   logic [15:0]    col_r;
   logic [15:0]    sel_col_r;
   logic [23:0]    row_r;
   logic [15:0]    enh_row_r;
   logic           addr_seen_r;
   logic           loading_r;
   logic           out_status_r;
   logic           selected_r;
   logic [7:0]     io_out_r;
   logic           io_oe_r;
   logic [7:0]     hreg_rd, dreg_rd, arr_rd;
   nlao_status_t   status_w;

   // ****************************************
   // command decode
   // ****************************************
   logic     go_w;
   nlao_op_t op_w;

   always_comb begin
      go_w = 1'b0;
      op_w = OP_READ;
      if (cmd_stb && ready_r) begin
         case (io_s)
            `NLAO_CMD_READ_GO, `NLAO_CMD_CB_READ: begin
               go_w = (cmd_r == `NLAO_CMD_READ);
               op_w = OP_READ;
            end
            `NLAO_CMD_CRD_SEQ: begin
               go_w = 1'b1;
               op_w = OP_CRD_SEQ;
            end
            `NLAO_CMD_CRD_END: begin
               go_w = 1'b1;
               op_w = OP_CRD_END;
            end
            `NLAO_CMD_PROG_GO: begin
               go_w = loading_r;
               op_w = OP_PROG;
            end
            `NLAO_CMD_CPROG_GO: begin
               go_w = loading_r;
               op_w = OP_CPROG;
            end
            default: begin
               go_w = 1'b0;
               op_w = OP_READ;
            end
         endcase
      end
   end

   // ****************************************
   // host side: commands, addresses, columns
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cmd_r        <= `NLAO_CMD_STATUS;
         addr_cnt_r   <= `NLAO_ADDR_DONE;
         col_r        <= 16'h0000;
         sel_col_r    <= 16'h0000;
         row_r        <= 24'h00_0000;
         enh_row_r    <= 16'h0000;
         addr_seen_r  <= 1'b0;
         loading_r    <= 1'b0;
         out_status_r <= 1'b1;
         selected_r   <= 1'b1;
      end else if (cmd_stb) begin
         if (io_s == `NLAO_CMD_STATUS) begin
            out_status_r <= 1'b1;
         end else if (io_s == `NLAO_CMD_STATUS_ENH) begin
            out_status_r <= 1'b1;
            cmd_r        <= io_s;
            addr_cnt_r   <= `NLAO_ADDR_ROW0;
         end else if (ready_r && io_s == `NLAO_CMD_READ) begin
            out_status_r <= 1'b0;
            col_r        <= sel_col_r;
            cmd_r        <= io_s;
            addr_cnt_r   <= `NLAO_ADDR_COL0;
            addr_seen_r  <= 1'b0;
            loading_r    <= 1'b0;
         end else if (ready_r && (io_s == `NLAO_CMD_PROG || io_s == `NLAO_CMD_CB_PROG)) begin
            // both openings keep the page register, so copyback data can be patched
            out_status_r <= 1'b0;
            cmd_r        <= io_s;
            addr_cnt_r   <= `NLAO_ADDR_COL0;
            loading_r    <= 1'b1;
         end else if (go_w) begin
            loading_r    <= 1'b0;
            addr_seen_r  <= 1'b0;
            cmd_r        <= io_s;
            if (op_w == OP_CRD_SEQ || op_w == OP_CRD_END) begin
               col_r     <= 16'h0000;
               sel_col_r <= 16'h0000;
            end
            if (op_w == OP_CRD_SEQ && !addr_seen_r) begin
               row_r <= row_r + 24'h00_0001;
            end
         end
      end else if (addr_stb && addr_cnt_r != `NLAO_ADDR_DONE) begin
         addr_cnt_r  <= addr_cnt_r + 3'h1;
         addr_seen_r <= (cmd_r != `NLAO_CMD_STATUS_ENH);
         if (cmd_r == `NLAO_CMD_STATUS_ENH) begin
            case (addr_cnt_r)
               `NLAO_ADDR_ROW0: enh_row_r[7:0]  <= io_s;
               `NLAO_ADDR_ROW1: enh_row_r[15:8] <= io_s;
               default: selected_r <= ({io_s, enh_row_r} >> `NLAO_LUN_SHIFT) == 24'(LUN_ID);
            endcase
         end else begin
            case (addr_cnt_r)
               `NLAO_ADDR_COL0: begin
                  col_r[7:0]     <= io_s;
                  sel_col_r[7:0] <= io_s;
               end
               `NLAO_ADDR_COL1: begin
                  col_r[15:8]     <= io_s;
                  sel_col_r[15:8] <= io_s;
               end
               `NLAO_ADDR_ROW0: row_r[7:0]   <= io_s;
               `NLAO_ADDR_ROW1: row_r[15:8]  <= io_s;
               default:         row_r[23:16] <= io_s;
            endcase
         end
      end else if (data_stb && loading_r && ready_r) begin
         col_r <= col_r + 16'h0001;
      end else if (re_fall && !out_status_r && selected_r) begin
         col_r <= col_r + 16'h0001;
      end
   end

   // ****************************************
   // array sequencer
   // ****************************************
   logic f_now;
   assign f_now = fault_s || !pins_s.wp_b;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_r       <= S_IDLE;
         op_r          <= OP_READ;
         kind_r        <= CP_A2H;
         ready_r       <= 1'b1;
         cnt_r         <= '0;
         fg_cnt_r      <= '0;
         bg_cnt_r      <= '0;
         bg_prog_r     <= 1'b0;
         launch_fail_r <= 1'b0;
         il_r          <= '0;
         arow_r        <= '0;
         last_fail_r   <= '0;
         prior_fail_r  <= '0;
      end else begin
         if (bg_cnt_r != '0) begin
            bg_cnt_r <= bg_cnt_r - CW'(1);
            if (bg_cnt_r == CW'(1) && bg_prog_r) begin
               // only the finishing address keeps a bit, so the or shows the last op alone
               last_fail_r  <= NIL'(launch_fail_r) << il_r;
               prior_fail_r <= last_fail_r;
            end
         end
         case (state_r)
            S_IDLE: begin
               if (go_w) begin
                  ready_r <= 1'b0;
                  op_r    <= op_w;
                  state_r <= S_WAITBG;
               end
            end
            S_WAITBG: begin
               // a new array step waits for the background operation to finish
               if (bg_cnt_r == '0) begin
                  cnt_r  <= '0;
                  arow_r <= row_r[PAW-1:0];
                  case (op_r)
                     OP_READ: kind_r <= CP_A2H;
                     OP_CRD_SEQ, OP_CRD_END: kind_r <= CP_D2H;
                     default: begin
                        kind_r        <= CP_H2A;
                        launch_fail_r <= f_now;
                        il_r          <= row_r[ILW-1:0];
                     end
                  endcase
                  // write protect blocks the array write and reports a failure
                  if ((op_r == OP_PROG || op_r == OP_CPROG) && !pins_s.wp_b) begin
                     last_fail_r  <= NIL'(1'b1) << row_r[ILW-1:0];
                     prior_fail_r <= last_fail_r;
                     ready_r <= 1'b1;
                     state_r <= S_IDLE;
                  end else begin
                     state_r <= S_COPY;
                  end
               end
            end
            S_COPY: begin
               cnt_r <= cnt_r + CAW'(1);
               if (cnt_r == COL_LAST) begin
                  case (op_r)
                     OP_READ: begin
                        fg_cnt_r <= CW'(TR_CYC);
                        state_r  <= S_TIMER;
                     end
                     OP_CRD_SEQ: begin
                        if (kind_r == CP_D2H) begin
                           kind_r <= CP_A2D;
                           arow_r <= row_r[PAW-1:0];
                           cnt_r  <= '0;
                        end else begin
                           bg_cnt_r  <= CW'(TR_CYC);
                           bg_prog_r <= 1'b0;
                           ready_r   <= 1'b1;
                           state_r   <= S_IDLE;
                        end
                     end
                     OP_CRD_END: begin
                        ready_r <= 1'b1;
                        state_r <= S_IDLE;
                     end
                     OP_PROG: begin
                        fg_cnt_r <= CW'(ARRAY_PROGRAM_TIME_CYC);
                        state_r  <= S_TIMER;
                     end
                     default: begin
                        bg_cnt_r  <= CW'(ARRAY_PROGRAM_TIME_CYC);
                        bg_prog_r <= 1'b1;
                        ready_r   <= 1'b1;
                        state_r   <= S_IDLE;
                     end
                  endcase
               end
            end
            S_TIMER: begin
               fg_cnt_r <= fg_cnt_r - CW'(1);
               if (fg_cnt_r == CW'(1)) begin
                  ready_r <= 1'b1;
                  state_r <= S_IDLE;
                  if (op_r == OP_PROG) begin
                     last_fail_r  <= NIL'(launch_fail_r) << il_r;
                     prior_fail_r <= last_fail_r;
                  end
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // ****************************************
   // page register, cache register, array
   // ****************************************
   logic in_copy;
   assign in_copy = (state_r == S_COPY);

   nlao_store #(.W(8), .DEPTH(PAGE_BYTES)) u_hreg (
      .mclk  (mclk),
      .we    ((in_copy && (kind_r == CP_A2H || kind_r == CP_D2H)) || (data_stb && loading_r && ready_r)),
      .waddr (in_copy ? cnt_r : col_r[CAW-1:0]),
      .wdata (in_copy ? ((kind_r == CP_A2H) ? arr_rd : dreg_rd) : io_s),
      .raddr (in_copy ? cnt_r : col_r[CAW-1:0]),
      .rdata (hreg_rd)
   );
   nlao_store #(.W(8), .DEPTH(PAGE_BYTES)) u_dreg (
      .mclk  (mclk),
      // a plain read fills the cache register too, so the first 31h hands that page out
      .we    (in_copy && (kind_r == CP_A2D || kind_r == CP_A2H)),
      .waddr (cnt_r),
      .wdata (arr_rd),
      .raddr (cnt_r),
      .rdata (dreg_rd)
   );
   nlao_store #(.W(8), .DEPTH(PAGE_BYTES * NPAGES)) u_arr (
      .mclk  (mclk),
      .we    (in_copy && kind_r == CP_H2A),
      .waddr ({arow_r, cnt_r}),
      .wdata (hreg_rd),
      .raddr ({arow_r, cnt_r}),
      .rdata (arr_rd)
   );

   // ****************************************
   // status byte and output pins
   // ****************************************
   always_comb begin
      status_w.write_unprot      = pins_s.wp_b;
      status_w.lun_ready         = ready_r;
      status_w.array_idle_bit    = (bg_cnt_r == '0) && (state_r == S_IDLE);
      status_w.vendor_status_bit = `NLAO_VSP_VALUE;
      status_w.rsvd              = 2'h0;
      status_w.prior_op_fail_bit = |prior_fail_r;
      status_w.last_op_fail      = |last_fail_r;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         io_out_r <= 8'h00;
         io_oe_r  <= 1'b0;
      end else begin
         if (re_fall) begin
            io_out_r <= out_status_r ? status_w : hreg_rd;
         end
         io_oe_r <= selected_r && act && !pins_s.re_b;
      end
   end

   assign io_out    = io_out_r;
   assign io_oe     = io_oe_r;
   assign rdy_bsy_b = ready_r;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_cache_cmd;
      go_w && (op_w == OP_CRD_SEQ || op_w == OP_CRD_END);
   endsequence
   sequence s_ready_back(nlao_op_t o);
      $rose(ready_r) && op_r == o;
   endsequence

   a_status_fixed:  assert property (status_w.rsvd == 2'h0 && status_w.lun_ready == ready_r)
      else $error("status layout wrong");
   a_idle_low_busy: assert property (!ready_r |-> !status_w.array_idle_bit)
      else $error("array idle set while busy");
   a_go_busy_pin:   assert property (go_w |=> !rdy_bsy_b)
      else $error("busy pin not lowered");
   a_cache_busy:    assert property (s_cache_cmd |=> !ready_r ##1 !ready_r)
      else $error("cache command did not go busy");
   a_cache_col0:    assert property (s_cache_cmd |=> col_r == 16'h0000)
      else $error("cache output not at column zero");
   a_seq_next_row:  assert property (go_w && op_w == OP_CRD_SEQ && !addr_seen_r |=>
                                     row_r == 24'($past(row_r) + 24'h00_0001))
      else $error("sequential cache did not advance row");
   a_end_no_bg:     assert property (s_ready_back(OP_CRD_END) |-> bg_cnt_r == '0 ##1 bg_cnt_r == '0)
      else $error("end command started a background read");
   a_prog_drained:  assert property (s_ready_back(OP_PROG) |-> status_w.array_idle_bit)
      else $error("ready before array drained");
   a_fail_hold:     assert property (ready_r && $past(ready_r) && bg_cnt_r == '0 && $past(bg_cnt_r) == '0 &&
                                     $past(state_r) == S_IDLE |-> $stable(status_w.last_op_fail))
      else $error("fail bit moved while ready");
   a_row_order:     assert property (addr_stb && addr_cnt_r == `NLAO_ADDR_ROW0 && cmd_r != `NLAO_CMD_STATUS_ENH
                                     |=> row_r[7:0] == $past(io_s))
      else $error("first row byte misplaced");
   a_unsel_quiet:   assert property (!selected_r |=> !io_oe_r)
      else $error("unselected lun drives bus");
endmodule : nlao_top

// ### dv/nlao_host.sv
// host controller model driving the nand bus pins
`timescale 1ns/100ps
module nlao_host import nlao_pkg::*; (
   input  wire logic       mclk,
   input  wire logic [7:0] io_out,
   input  wire logic       io_oe,
   output nlao_pins_t      pins,
   output logic      [7:0] io_in
);
   initial begin
      pins  = 6'b000111;
      io_in = 8'h00;
   end
   // 5 cycles per strobe phase, so the synchroniser never drops an edge
   task automatic gap;
      repeat (5) @(posedge mclk);
      #1;
   endtask : gap
   task automatic put(input logic c, input logic a, input logic [7:0] b);
      pins.cle  = c;
      pins.ale  = a;
      io_in     = b;
      pins.we_b = 1'b0;
      gap();
      pins.we_b = 1'b1;
      gap();
      pins.cle  = 1'b0;
      pins.ale  = 1'b0;
      io_in     = ~b;
      @(posedge mclk);
      #1;
   endtask : put
   task automatic addr(input logic [15:0] col, input logic [23:0] row);
      logic [39:0] v;
      v = {row, col};
      for (int i = 0; i < 5; i++) begin
         put(1'b0, 1'b1, v[8*i+:8]);
      end
   endtask : addr
   task automatic get(output logic [7:0] d, output logic oe);
      pins.re_b = 1'b0;
      gap();
      d         = io_out;
      oe        = io_oe;
      pins.re_b = 1'b1;
      gap();
   endtask : get
endmodule : nlao_host

// ### dv/tb_nlao_top.sv
// self-checking bench for the nand lun sequencer
`timescale 1ns/100ps
module tb_nlao_top import nlao_pkg::*; ;
   logic       mclk, rst_b, array_fault, io_oe, rdy_bsy_b;
   logic [7:0] io_in, io_out, d;
   logic       oe;
   nlao_pins_t pins;
   int         n_errors, compares;
   nlao_top #(.TR_CYC(8), .ARRAY_PROGRAM_TIME_CYC(12)) DUT (.mclk(mclk), .rst_b(rst_b), .pins(pins), .io_in(io_in),
      .array_fault(array_fault), .io_out(io_out), .io_oe(io_oe), .rdy_bsy_b(rdy_bsy_b));
   nlao_host h (.mclk(mclk), .io_out(io_out), .io_oe(io_oe), .pins(pins), .io_in(io_in));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic close_out;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask : check
   // busy is seen late through the synchroniser, so give it time to fall first
   task automatic wait_ready;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 2000 && rdy_bsy_b !== 1'b1; i++) begin
         @(posedge mclk);
      end
      #1;
      if (rdy_bsy_b !== 1'b1) begin
         n_errors++;
         close_out();
      end
   endtask : wait_ready
   task automatic cmd(input logic [7:0] c);
      h.put(1'b1, 1'b0, c);
   endtask : cmd
   task automatic status(input logic [7:0] exp);
      cmd(8'h70);
      h.get(d, oe);
      check("status_byte", exp, d);
      check("io_oe", 8'h01, {7'h00, oe});
   endtask : status
   task automatic lun_sel(input logic [23:0] row);
      cmd(8'h78);
      for (int i = 0; i < 3; i++) begin
         h.put(1'b0, 1'b1, row[8*i+:8]);
      end
   endtask : lun_sel
   task automatic prog_page(input logic [3:0] row, input logic fault, input logic [7:0] conf = 8'h10);
      array_fault = fault;
      cmd(8'h80);
      h.addr(16'h0000, {20'h0_0000, row});
      for (int i = 0; i < 16; i++) begin
         h.put(1'b0, 1'b0, {row, i[3:0]});
      end
      cmd(conf);
      wait_ready();
   endtask : prog_page
   task automatic read_page(input logic [3:0] row, input logic [15:0] col, input logic [7:0] go = 8'h30);
      cmd(8'h00);
      h.addr(col, {20'h0_0000, row});
      cmd(go);
      wait_ready();
   endtask : read_page
   task automatic expect_data(input logic [7:0] first, input int n);
      for (int i = 0; i < n; i++) begin
         h.get(d, oe);
         check("page_byte", first + i[7:0], d);
         check("io_oe", 8'h01, {7'h00, oe});
      end
   endtask : expect_data
   initial begin
      rst_b       = 1'b0;
      array_fault = 1'b0;
      n_errors    = 0;
      compares    = 0;
      repeat (2) @(posedge mclk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      status(8'he0);
      h.pins.wp_b = 1'b0;
      status(8'h60);
      h.pins.wp_b = 1'b1;
      lun_sel(24'h10_0000);
      h.get(d, oe);
      check("io_oe", 8'h00, {7'h00, oe});
      lun_sel(24'h00_0000);
      h.get(d, oe);
      check("status_byte", 8'he0, d);
      prog_page(4'h1, 1'b0);
      status(8'he0);
      read_page(4'h1, 16'h0003);
      status(8'he0);
      cmd(8'h00);
      expect_data(8'h13, 4);
      prog_page(4'h2, 1'b1);
      status(8'he1);
      prog_page(4'h3, 1'b0);
      status(8'he2);
      read_page(4'h1, 16'h0005);
      cmd(8'h31);
      wait_ready();
      expect_data(8'h10, 2);
      cmd(8'h3f);
      wait_ready();
      expect_data(8'h20, 2);
      read_page(4'h3, 16'h0000, 8'h35);
      expect_data(8'h30, 1);
      cmd(8'h85);
      h.addr(16'h0005, 24'h00_0005);
      h.put(1'b0, 1'b0, 8'ha5);
      cmd(8'h10);
      wait_ready();
      read_page(4'h5, 16'h0004);
      expect_data(8'h34, 1);
      expect_data(8'ha5, 1);
      prog_page(4'h6, 1'b1, 8'h15);
      prog_page(4'h7, 1'b0);
      status(8'he2);
      read_page(4'h6, 16'h0000);
      expect_data(8'h60, 2);
      close_out();
   end
endmodule : tb_nlao_top
